// *** inc/coproc_guard_pkg.sv ***
// Constants shared by the request queue and error guard of the peripheral coprocessor.
package coproc_guard_pkg;
   // Register bus geometry and byte offsets.
   localparam int unsigned AXI_ADDR_W      = 4;
   localparam int unsigned AXI_DATA_W      = 32;
   localparam logic [3:0]  CTRL_OFFSET     = 4'h0;
   localparam logic [3:0]  ERRSTAT_OFFSET  = 4'h4;
   localparam logic [3:0]  QSTAT_OFFSET    = 4'h8;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;
   // Global control register fields and reset value.
   localparam int unsigned CTRL_PART_EN_BIT   = 0;
   localparam int unsigned CTRL_WDOG_EN_BIT   = 1;
   localparam int unsigned CTRL_PART_SIZE_LSB = 8;
   localparam int unsigned CTRL_WDOG_THR_LSB  = 16;
   localparam int unsigned CTRL_EPRIO_LSB  = 24;
   localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
   // Error status register fields.
   localparam int unsigned ES_CHAN_LSB     = 8;
   localparam int unsigned ES_ADDR_LSB     = 16;
   // Error cause bits.
   localparam int unsigned CAUSE_W         = 5;
   localparam int unsigned ERR_PART_WRITE  = 0;
   localparam int unsigned ERR_CTX_LOAD    = 1;
   localparam int unsigned ERR_WATCHDOG    = 2;
   localparam int unsigned ERR_OPCODE      = 3;
   localparam int unsigned ERR_ADDRESS     = 4;
   // Field widths.
   localparam int unsigned PRIO_W          = 8;
   localparam int unsigned CHAN_W          = 5;
   localparam int unsigned PC_W            = 16;
   localparam int unsigned FCNT_W          = 16;
   localparam int unsigned QDEPTH          = 2;
   // Code memory size in 16-bit instruction words.
   localparam logic [16:0] CODE_MEM_WORDS  = 17'h0_1000;
   // One context occupies eight parameter-RAM words.
   localparam int unsigned CTX_SHIFT       = 3;
   // Opcode class is the top five bits; a set mask bit marks a legal class.
   localparam int unsigned OPC_LSB         = 11;
   localparam logic [31:0] LEGAL_OPC_MASK  = 32'h7FFF_FFFE;
   // Queue status register bit positions.
   localparam int unsigned QS_CPU_PEND_LSB = 0;
   localparam int unsigned QS_SELF_PEND_LSB = 2;
   localparam int unsigned QS_CPU_FULL_BIT = 4;
   localparam int unsigned QS_SELF_FULL_BIT = 5;
   localparam int unsigned QS_STALL_BIT    = 6;
endpackage

// *** tb/arbiter_model.sv ***
// Behavioural interrupt arbiter that acknowledges the coprocessor request nodes.
`timescale 1ns/1ps
module arbiter_model
(
   // Clock, reset and pacing
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire logic       holdOff,
   // Request nodes
   input  wire logic [1:0] cpuNodePending,
   input  wire logic [1:0] selfNodePending,
   input  wire logic       selfQueueFull,
   output logic [1:0]      cpuNodeAck,
   output logic [1:0]      selfNodeAck
);
   // Skipping the cycle after an ack stops one pending flag from being acknowledged twice.
   always_ff @(posedge core_clk)
   begin
      cpuNodeAck  <= (reset || holdOff || selfQueueFull) ? 2'h0 : cpuNodePending & ~cpuNodeAck;
      selfNodeAck <= (reset || holdOff) ? 2'h0 : selfNodePending & ~selfNodeAck;
   end
endmodule // arbiter_model

// *** tb/tb.sv ***
// Self-checking bench for the coprocessor request queue and error guard.
`timescale 1ns/1ps
module tb;
   import coproc_guard_pkg::*;
   logic            core_clk = 1'b0, reset = 1'b1, holdOff = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic            arvalid = 1'b0, rready = 1'b0, exitReq = 1'b0, chanStart = 1'b0, fetchStrobe = 1'b0;
   logic            execValid = 1'b0, pcUpdate = 1'b0, pramWrite = 1'b0, requestReceived = 1'b0;
   logic            awready, wready, bvalid, arready, rvalid, coreStall, errorExit, cpuQueueFull, selfQueueFull;
   logic [3:0]      awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
   logic [1:0]      cpuServiceType = 2'h0, selfServiceType = 2'h1, exitServiceType = 2'h0;
   logic [1:0]      bresp, rresp, rs, cpuNodePending, selfNodePending, cpuNodeAck, selfNodeAck;
   logic [31:0]     wdata = 32'h0, rdata, rd;
   logic [7:0]      exitPriority = 8'h0, requestPriority = 8'h0, eprio, lastErr, q[$];
   logic [4:0]      chanNumber = 5'h0;
   logic [15:0]     execAddr = 16'h0, execOpcode = 16'h0, pramAddr = 16'h0;
   logic [16:0]     pcSum = 17'h0;
   logic [1:0][7:0] cpuNodePriority, selfNodePriority;
   int              failures = 0, samplesChecked = 0, cyc = 0;
   // Entry 6 arms the watchdog with a threshold far above that channel's fetches.
   localparam logic [23:0] CFG [8] = '{24'h201, 24'h201, 24'h30002, 24'h0, 24'h0, 24'h0, 24'hFF0202, 24'h1};
   localparam int KIND [8] = '{0, 1, 2, 3, 3, 4, 0, 1};
   localparam int CAUSE [8] = '{ERR_PART_WRITE, ERR_CTX_LOAD, ERR_WATCHDOG, ERR_OPCODE, ERR_ADDRESS, ERR_ADDRESS, 0, 1};
   coproc_request_queue_and_error_guard u_coproc_request_queue_and_error_guard (.*);
   arbiter_model u_arbiter_model (.*);
   always #4 core_clk = ~core_clk;
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         failures++;
         stop_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samplesChecked++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      // One edge between transfers keeps the previous handshake's release from being overwritten.
      @(posedge core_clk);
      awaddr <= a;
      araddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= {3{w}};
      {arvalid, rready} <= {2{!w}};
      do
      begin
         @(posedge core_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (arready) arvalid <= 1'b0;
      end
      while (!(w ? bvalid : rvalid));
      {bready, rready} <= 2'h0;
      rd = rdata;
      rs = w ? bresp : rresp;
   endtask
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", samplesChecked, failures);
      if (failures == 0 && samplesChecked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      void'($urandom(32'h786CD388));
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      repeat (2) @(posedge core_clk);
      bus(1'b0, CTRL_OFFSET, 32'h0);
      chk(rd, CTRL_RESET);
      bus(1'b0, 4'hC, 32'h0);
      chk(rs, RESP_SLVERR);
      for (int i = 0; i < 5; i++)
      begin
         q.push_back(8'($urandom) | ((i inside {2, 3}) ? 8'hC0 : 8'h00));
         exitReq <= 1'b1;
         exitServiceType <= (i inside {2, 3}) ? selfServiceType : cpuServiceType;
         exitPriority <= q[i];
         @(posedge core_clk);
      end
      exitReq <= 1'b0;
      #1;
      chk({coreStall, cpuQueueFull, selfQueueFull, selfNodePending}, 5'h1F);
      chk({cpuNodePriority, selfNodePriority}, {q[1], q[0], q[3], q[2]});
      holdOff <= 1'b0;
      for (int i = 0; i < 20 && coreStall === 1'b1; i++) @(posedge core_clk) #1;
      chk({coreStall, cpuNodePriority[cpuNodePending[1]]}, {1'b0, q[4]});
      for (int k = 0; k < 8; k++)
      begin
         eprio = 8'($urandom);
         bus(1'b1, CTRL_OFFSET, {eprio, CFG[k]});
         bus(1'b1, ERRSTAT_OFFSET, 32'h1F);
         chanNumber <= 5'($urandom);
         chanStart <= 1'b1;
         @(posedge core_clk);
         chanStart <= 1'b0;
         pramAddr <= 16'($urandom % 16);
         requestPriority <= 8'(2 + $urandom % 254);
         execOpcode <= {(k == 3) ? 5'h00 : 5'h01, 11'($urandom)};
         execAddr <= {(k == 4) ? 4'h1 : 4'h0, 12'($urandom)};
         pcSum <= {1'b1, 16'($urandom)};
         {pramWrite, requestReceived, fetchStrobe, execValid, pcUpdate} <= 5'h10 >> KIND[k];
         repeat ((k == 2) ? 3 : 1) @(posedge core_clk);
         {pramWrite, requestReceived, fetchStrobe, execValid, pcUpdate} <= 5'h00;
         #1;
         chk({errorExit, cpuNodePending[0]}, {2{k != 6}});
         chk(cpuNodePriority[0], (k == 6) ? lastErr : eprio);
         if (k != 6) lastErr = eprio;
         bus(1'b0, ERRSTAT_OFFSET, 32'h0);
         chk(rd & ((k == 6) ? 32'h1F : 32'hFFFF_1F1F),
             (k == 6) ? 32'h0 : {execAddr, 3'h0, chanNumber, 3'h0, 5'h01 << CAUSE[k]});
      end
      stop_test();
   end
endmodule // tb

// *** verilog/coproc_request_queue_and_error_guard.sv ***
// Service-request queues and error guard of the peripheral coprocessor.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module coproc_request_queue_and_error_guard
(
   // Clock and reset
   input  wire logic                                      core_clk,
   input  wire logic                                      reset,
   // AXI4-Lite write address, data and response
   input  wire logic [coproc_guard_pkg::AXI_ADDR_W-1:0]   awaddr,
   input  wire logic                                      awvalid,
   output logic                                           awready,
   input  wire logic [31:0]                               wdata,
   input  wire logic [3:0]                                wstrb,
   input  wire logic                                      wvalid,
   output logic                                           wready,
   output logic [1:0]                                     bresp,
   output logic                                           bvalid,
   input  wire logic                                      bready,
   // AXI4-Lite read
   input  wire logic [coproc_guard_pkg::AXI_ADDR_W-1:0]   araddr,
   input  wire logic                                      arvalid,
   output logic                                           arready,
   output logic [31:0]                                    rdata,
   output logic [1:0]                                     rresp,
   output logic                                           rvalid,
   input  wire logic                                      rready,
   // Service-type mapping
   input  wire logic [1:0]                                cpuServiceType,
   input  wire logic [1:0]                                selfServiceType,
   // Exit requests from the processing core
   input  wire logic                                      exitReq,
   input  wire logic [1:0]                                exitServiceType,
   input  wire logic [coproc_guard_pkg::PRIO_W-1:0]       exitPriority,
   // Execution events from the processing core
   input  wire logic                                      chanStart,
   input  wire logic [coproc_guard_pkg::CHAN_W-1:0]       chanNumber,
   input  wire logic                                      fetchStrobe,
   input  wire logic                                      execValid,
   input  wire logic [coproc_guard_pkg::PC_W-1:0]         execAddr,
   input  wire logic [15:0]                               execOpcode,
   input  wire logic                                      pcUpdate,
   input  wire logic [coproc_guard_pkg::PC_W:0]           pcSum,
   input  wire logic                                      pramWrite,
   input  wire logic [15:0]                               pramAddr,
   input  wire logic                                      requestReceived,
   input  wire logic [coproc_guard_pkg::PRIO_W-1:0]       requestPriority,
   // Core control
   output logic                                           coreStall,
   output logic                                           errorExit,
   // Request nodes towards the interrupt arbiter
   output logic [1:0]                                     cpuNodePending,
   output logic [1:0][coproc_guard_pkg::PRIO_W-1:0]       cpuNodePriority,
   output logic [1:0]                                     selfNodePending,
   output logic [1:0][coproc_guard_pkg::PRIO_W-1:0]       selfNodePriority,
   input  wire logic [1:0]                                cpuNodeAck,
   input  wire logic [1:0]                                selfNodeAck,
   output logic                                           cpuQueueFull,
   output logic                                           selfQueueFull
);
   import coproc_guard_pkg::*;

   logic [31:0]            ctrl_ff;
   logic [CAUSE_W-1:0]     cause_ff;
   logic [CHAN_W-1:0]      errChan_ff;
   logic [PC_W-1:0]        errAddr_ff;
   logic [FCNT_W-1:0]      fetchCnt_ff;
   logic [1:0]             cpuPend_ff, selfPend_ff;
   logic [1:0][PRIO_W-1:0] cpuPrio_ff, selfPrio_ff;
   logic                   cpuFull_ff, selfFull_ff, stall_ff, errExit_ff;
   logic                   exitHold_ff, holdSelf_ff, holdDrop_ff, errHold_ff;
   logic [PRIO_W-1:0]      holdPrio_ff, errPrio_ff;
   logic                   awHave_ff, wHave_ff, awready_ff, wready_ff, bvalid_ff;
   logic                   arready_ff, rvalid_ff;
   logic [AXI_ADDR_W-1:0]  awAddr_ff;
   logic [31:0]            wData_ff, rdata_ff;
   logic [3:0]             wStrb_ff;
   logic [1:0]             bresp_ff, rresp_ff;

   // Control fields.
   logic                   partEn, wdogEn;
   logic [7:0]             partSize, wdogThr;
   logic [PRIO_W-1:0]      errPrioField;
   assign partEn       = ctrl_ff[CTRL_PART_EN_BIT];
   assign wdogEn       = ctrl_ff[CTRL_WDOG_EN_BIT];
   assign partSize     = ctrl_ff[CTRL_PART_SIZE_LSB +: 8];
   assign wdogThr      = ctrl_ff[CTRL_WDOG_THR_LSB +: 8];
   assign errPrioField = ctrl_ff[CTRL_EPRIO_LSB +: PRIO_W];

   // Error detection. Checks are combinational on the core's strobes so the exit happens
   // at the very edge after the offending event.
   logic [CAUSE_W-1:0]     cause;
   logic [15:0]            saveEnd;
   logic [4:0]             opcClass;
   logic                   errNow;
   always_comb
   begin
      saveEnd  = 16'(partSize) << CTX_SHIFT;
      opcClass = execOpcode[OPC_LSB +: 5];
      cause    = '0;
      // Partition checks only exist when enabled; by default the area is empty (size zero).
      cause[ERR_PART_WRITE] = partEn && pramWrite && (pramAddr < saveEnd);
      cause[ERR_CTX_LOAD]   = partEn && requestReceived && ({8'h00, requestPriority} >= {8'h00, partSize});
      cause[ERR_WATCHDOG]   = wdogEn && ((fetchStrobe && !chanStart && ((fetchCnt_ff + 16'h0001) == {8'h00, wdogThr}))
                              || (requestReceived && (wdogThr == 8'h00)));
      cause[ERR_OPCODE]     = execValid && !LEGAL_OPC_MASK[opcClass];
      cause[ERR_ADDRESS]    = (execValid && ({1'b0, execAddr} >= CODE_MEM_WORDS))
                              || (pcUpdate && pcSum[PC_W]);
      errNow   = (|cause) && !errHold_ff;
   end

   // The counter follows the running channel only; a 32-bit instruction strobes twice.
   always_ff @(posedge core_clk)
   begin
      if (reset || chanStart)
         fetchCnt_ff <= '0;
      else if (fetchStrobe && (fetchCnt_ff != 16'hFFFF))
         fetchCnt_ff <= fetchCnt_ff + 16'h0001;
   end

   // Posting. An error takes the CPU queue first; a newer request never overtakes a held one.
   logic [1:0] cpuIdx, selfIdx;
   logic       cpuFree, selfFree, errCand, exitCand, exitSelf, exitDrop;
   logic       postErr, postExitCpu, postExitSelf, exitGone;
   logic [PRIO_W-1:0] exitPrio, errPrio;
   logic       nxt_exitHold, nxt_errHold;
   always_comb
   begin
      cpuFree  = !(&cpuPend_ff);
      selfFree = !(&selfPend_ff);
      cpuIdx   = cpuPend_ff[0] ? 2'b10 : 2'b01;
      selfIdx  = selfPend_ff[0] ? 2'b10 : 2'b01;
      errCand  = errHold_ff || errNow;
      errPrio  = errHold_ff ? errPrio_ff : errPrioField;
      exitCand = exitHold_ff || exitReq;
      exitSelf = exitHold_ff ? holdSelf_ff : (exitServiceType == selfServiceType);
      exitDrop = exitHold_ff ? holdDrop_ff
                             : ((exitServiceType != selfServiceType) && (exitServiceType != cpuServiceType));
      exitPrio = exitHold_ff ? holdPrio_ff : exitPriority;
      postErr      = errCand && cpuFree;
      postExitCpu  = exitCand && !exitDrop && !exitSelf && cpuFree && !postErr;
      postExitSelf = exitCand && !exitDrop && exitSelf && selfFree;
      exitGone     = postExitCpu || postExitSelf || exitDrop;
      nxt_exitHold = exitCand && !exitGone;
      nxt_errHold  = errCand && !postErr;
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         exitHold_ff <= 1'b0;
         holdSelf_ff <= 1'b0;
         holdDrop_ff <= 1'b0;
         holdPrio_ff <= '0;
         errHold_ff  <= 1'b0;
         errPrio_ff  <= '0;
         stall_ff    <= 1'b0;
      end
      else
      begin
         exitHold_ff <= nxt_exitHold;
         holdSelf_ff <= exitSelf;
         holdDrop_ff <= exitDrop;
         holdPrio_ff <= exitPrio;
         errHold_ff  <= nxt_errHold;
         errPrio_ff  <= errPrio;
         // Stall rises only while a request waits, for a full queue or behind an error taking the CPU queue.
         stall_ff    <= nxt_exitHold || nxt_errHold;
      end
   end

   // Queue entries. An acknowledge only clears a pending entry, and only free entries are
   // written, so a set and a clear never meet on one entry.
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         cpuPend_ff  <= '0;
         selfPend_ff <= '0;
         cpuPrio_ff  <= '0;
         selfPrio_ff <= '0;
         cpuFull_ff  <= 1'b0;
         selfFull_ff <= 1'b0;
      end
      else
      begin
         cpuPend_ff  <= (cpuPend_ff & ~cpuNodeAck) | ((postErr || postExitCpu) ? cpuIdx : 2'b00);
         selfPend_ff <= (selfPend_ff & ~selfNodeAck) | (postExitSelf ? selfIdx : 2'b00);
         for (int i = 0; i < QDEPTH; i++)
         begin
            if ((postErr || postExitCpu) && cpuIdx[i])
               cpuPrio_ff[i] <= postErr ? errPrio : exitPrio;
            if (postExitSelf && selfIdx[i])
               selfPrio_ff[i] <= exitPrio;
         end
         // The self full flag drives the arbiter's self-only round; both full flags drive the status register.
         cpuFull_ff  <= &((cpuPend_ff & ~cpuNodeAck) | ((postErr || postExitCpu) ? cpuIdx : 2'b00));
         selfFull_ff <= &((selfPend_ff & ~selfNodeAck) | (postExitSelf ? selfIdx : 2'b00));
      end
   end

   // Register bus write side. Address and data are taken in either order.
   logic [AXI_ADDR_W-1:0] wrAddr;
   logic [31:0]           wrData;
   logic [3:0]            wrStrb;
   logic                  awTake, wTake, haveA, haveW, doWrite, nxt_bvalid, esClear;
   always_comb
   begin
      awTake     = awvalid && awready_ff;
      wTake      = wvalid && wready_ff;
      haveA      = awHave_ff || awTake;
      haveW      = wHave_ff || wTake;
      doWrite    = haveA && haveW;
      wrAddr     = awHave_ff ? awAddr_ff : awaddr;
      wrData     = wHave_ff ? wData_ff : wdata;
      wrStrb     = wHave_ff ? wStrb_ff : wstrb;
      nxt_bvalid = doWrite || (bvalid_ff && !bready);
      esClear    = doWrite && (wrAddr == ERRSTAT_OFFSET) && wrStrb[0];
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         awHave_ff  <= 1'b0;
         wHave_ff   <= 1'b0;
         awAddr_ff  <= '0;
         wData_ff   <= '0;
         wStrb_ff   <= '0;
         awready_ff <= 1'b0;
         wready_ff  <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= RESP_OKAY;
      end
      else
      begin
         awHave_ff  <= haveA && !doWrite;
         wHave_ff   <= haveW && !doWrite;
         if (awTake)
            awAddr_ff <= awaddr;
         if (wTake)
         begin
            wData_ff <= wdata;
            wStrb_ff <= wstrb;
         end
         awready_ff <= !(haveA && !doWrite) && !nxt_bvalid;
         wready_ff  <= !(haveW && !doWrite) && !nxt_bvalid;
         bvalid_ff  <= nxt_bvalid;
         if (doWrite)
            bresp_ff <= (wrAddr == CTRL_OFFSET || wrAddr == ERRSTAT_OFFSET || wrAddr == QSTAT_OFFSET)
                        ? RESP_OKAY : RESP_SLVERR;
      end
   end

   // Control register with byte lanes.
   always_ff @(posedge core_clk)
   begin
      if (reset)
         ctrl_ff <= CTRL_RESET;
      else if (doWrite && (wrAddr == CTRL_OFFSET))
         for (int b = 0; b < 4; b++)
            if (wrStrb[b])
               ctrl_ff[b*8 +: 8] <= wrData[b*8 +: 8];
   end

   // Error status: a write of ones clears cause bits, but a new error in the same cycle wins.
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         cause_ff   <= '0;
         errChan_ff <= '0;
         errAddr_ff <= '0;
         errExit_ff <= 1'b0;
      end
      else
      begin
         cause_ff   <= (cause_ff & ~(esClear ? wrData[CAUSE_W-1:0] : '0)) | (errNow ? cause : '0);
         if (errNow)
         begin
            errChan_ff <= chanNumber;
            errAddr_ff <= execAddr;
         end
         errExit_ff <= errNow;
      end
   end

   // Register bus read side.
   logic [31:0] rdMux;
   logic        rdHit;
   always_comb
   begin
      rdMux = '0;
      rdHit = 1'b1;
      unique case (araddr)
         CTRL_OFFSET:    rdMux = ctrl_ff;
         ERRSTAT_OFFSET:
         begin
            rdMux[CAUSE_W-1:0]                = cause_ff;
            rdMux[ES_CHAN_LSB +: CHAN_W]      = errChan_ff;
            rdMux[ES_ADDR_LSB +: PC_W]        = errAddr_ff;
         end
         QSTAT_OFFSET:
         begin
            rdMux[QS_CPU_PEND_LSB +: 2]  = cpuPend_ff;
            rdMux[QS_SELF_PEND_LSB +: 2] = selfPend_ff;
            rdMux[QS_CPU_FULL_BIT]       = cpuFull_ff;
            rdMux[QS_SELF_FULL_BIT]      = selfFull_ff;
            rdMux[QS_STALL_BIT]          = stall_ff;
         end
         default:        rdHit = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= '0;
         rresp_ff   <= RESP_OKAY;
      end
      else
      begin
         rvalid_ff  <= (arvalid && arready_ff) || (rvalid_ff && !rready);
         arready_ff <= !((arvalid && arready_ff) || (rvalid_ff && !rready));
         if (arvalid && arready_ff)
         begin
            rdata_ff <= rdMux;
            rresp_ff <= rdHit ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   assign awready          = awready_ff;
   assign wready           = wready_ff;
   assign bvalid           = bvalid_ff;
   assign bresp            = bresp_ff;
   assign arready          = arready_ff;
   assign rvalid           = rvalid_ff;
   assign rdata            = rdata_ff;
   assign rresp            = rresp_ff;
   assign coreStall        = stall_ff;
   assign errorExit        = errExit_ff;
   assign cpuNodePending   = cpuPend_ff;
   assign cpuNodePriority  = cpuPrio_ff;
   assign selfNodePending  = selfPend_ff;
   assign selfNodePriority = selfPrio_ff;
   assign cpuQueueFull     = cpuFull_ff;
   assign selfQueueFull    = selfFull_ff;

   property p_err_exit;
      @(posedge core_clk) disable iff (reset) (|cause && !errHold_ff) |=> (errorExit && cause_ff != '0);
   endproperty
   a_err_exit: assert property (p_err_exit) else $error("Error did not exit channel.");

   // Entries that survive this edge's acknowledge; the error entry must come on top of them.
   logic [1:0] cpuKeep;
   assign cpuKeep = cpuPend_ff & ~cpuNodeAck;
   property p_err_to_cpu;
      @(posedge core_clk) disable iff (reset) (errNow && cpuFree)
         |=> ($countones(cpuNodePending) > $countones($past(cpuKeep)));
   endproperty
   a_err_to_cpu: assert property (p_err_to_cpu) else $error("Error request not placed in CPU queue.");

   property p_stall_full;
      @(posedge core_clk) disable iff (reset) (exitReq && !exitHold_ff && !errCand && !exitDrop && !exitSelf && (&cpuPend_ff)) |=> coreStall;
   endproperty
   a_stall_full: assert property (p_stall_full) else $error("Core not stalled on full CPU queue.");

   property p_no_idle_stall;
      @(posedge core_clk) disable iff (reset) (!exitReq && !exitHold_ff && !errCand) |=> !coreStall;
   endproperty
   a_no_idle_stall: assert property (p_no_idle_stall) else $error("Core stalled with nothing to post.");

   property p_full_flag;
      @(posedge core_clk) disable iff (reset) ##1 (selfQueueFull == (&selfNodePending)) && (cpuQueueFull == (&cpuNodePending));
   endproperty
   a_full_flag: assert property (p_full_flag) else $error("Queue full flag disagrees with entries.");

   property p_ack_frees;
      @(posedge core_clk) disable iff (reset) (selfPend_ff[0] && selfNodeAck[0]) |=> !selfNodePending[0];
   endproperty
   a_ack_frees: assert property (p_ack_frees) else $error("Acknowledged entry still pending.");

   property p_wdog_zero;
      @(posedge core_clk) disable iff (reset) (wdogEn && wdogThr == 8'h00 && requestReceived && !errHold_ff) |=> cause_ff[ERR_WATCHDOG];
   endproperty
   a_wdog_zero: assert property (p_wdog_zero) else $error("Zero watchdog threshold did not fault.");

   property p_part_zero;
      @(posedge core_clk) disable iff (reset) (partEn && partSize == 8'h00 && requestReceived && !errHold_ff) |=> cause_ff[ERR_CTX_LOAD];
   endproperty
   a_part_zero: assert property (p_part_zero) else $error("Zero save area did not fault.");

   property p_no_part_off;
      @(posedge core_clk) disable iff (reset) !partEn |-> !cause[ERR_PART_WRITE] && !cause[ERR_CTX_LOAD];
   endproperty
   a_no_part_off: assert property (p_no_part_off) else $error("Partition fault while disabled.");

   property p_cnt_restart;
      @(posedge core_clk) disable iff (reset) chanStart |=> (fetchCnt_ff == '0);
   endproperty
   a_cnt_restart: assert property (p_cnt_restart) else $error("Fetch count did not restart.");

   property p_pc_ovf;
      @(posedge core_clk) disable iff (reset) (pcUpdate && pcSum[PC_W] && !errHold_ff) |=> (errorExit && cause_ff[ERR_ADDRESS]);
   endproperty
   a_pc_ovf: assert property (p_pc_ovf) else $error("PC overflow not flagged.");

endmodule // coproc_request_queue_and_error_guard
